/* File: sir_irq_route.sv */
`timescale 1ns/1ps
`default_nettype none

module sir_irq_route #(
    parameter int NUM_DB = sir_pkg::NUM_DB
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_DB-1:0][15:0] doorbell_pending_status,
    input wire logic [15:0] rx_queue_pending_status,
    output logic [7:0] irq_destination_outputs,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        sir_pkg::sir_route_t [NUM_DB-1:0] db_route;
        sir_pkg::sir_route_t rxq_route;
        logic [7:0] dst;
        logic [7:0] status;
        logic [7:0] mask;
        logic [31:0] rdata;
        logic slverr;
        logic ready;
        sir_pkg::sir_phase_e phase;
    } sir_state_s;

    sir_state_s st_r;
    sir_state_s st_nxt;
    sir_pkg::sir_apb_req_s req;
    logic [NUM_DB:0][7:0] src_dst;
    logic [7:0] dst_comb;
    logic [7:0] dst_rise;

    assign req.sel = psel;
    assign req.enable = penable;
    assign req.write = pwrite;
    assign req.addr = paddr;
    assign req.wdata = pwdata;

    ////////////////////////////////////////////////////////////////////////
    // routing

    // one steering mux per doorbell
    genvar g;
    generate
        for (g = 0; g < NUM_DB; g++) begin : g_db
            sir_route_mux u_mux (
                .pending(doorbell_pending_status[g]),
                .route(st_r.db_route[g]),
                .dst(src_dst[g])
            );
        end
    endgenerate

    // receive queues share the same destination lines
    sir_route_mux u_rxq_mux (
        .pending(rx_queue_pending_status),
        .route(st_r.rxq_route),
        .dst(src_dst[NUM_DB])
    );

    // merge all sources per destination
    always_comb begin
        dst_comb = 8'h00;
        for (int i = 0; i <= NUM_DB; i++) begin
            dst_comb = dst_comb | src_dst[i];
        end
    end

    assign dst_rise = dst_comb & ~st_r.dst;

    ////////////////////////////////////////////////////////////////////////
    // register decode helpers

    // true when addr names the route register of doorbell d, high half when hi is set
    function automatic logic db_hit(input logic [11:0] a, input int d,
                                   input logic hi);
        logic [11:0] base;
        base = 12'(sir_pkg::DB_ROUTE_BASE + 12'(d) * sir_pkg::DB_ROUTE_STRIDE);
        if (hi) begin
            base = 12'(base + sir_pkg::DB_ROUTE_HI_OFS);
        end
        return a == base;
    endfunction : db_hit

    // eight route fields packed into one word
    function automatic logic [31:0] pack8(input sir_pkg::sir_route_t r,
                                          input logic hi);
        logic [31:0] w;
        w = 32'h0;
        for (int k = 0; k < sir_pkg::FIELDS_PER_REG; k++) begin
            w[4*k +: 4] = r[k + (hi ? 8 : 0)];
        end
        return w;
    endfunction : pack8

    ////////////////////////////////////////////////////////////////////////
    // next state

    // apb slave with one wait-free access, plus sticky destination events
    always_comb begin
        logic hit;
        logic acc;
        hit = 1'b0;
        acc = 1'b0;
        st_nxt = st_r;
        st_nxt.dst = dst_comb;
        st_nxt.ready = 1'b0;
        st_nxt.phase = sir_pkg::SIR_IDLE;
        st_nxt.status = st_r.status;
        if (req.sel && !req.enable) begin
            st_nxt.phase = sir_pkg::SIR_ACCESS;
            st_nxt.ready = 1'b1;
            st_nxt.rdata = sir_pkg::ERR_DATA;
            st_nxt.slverr = 1'b0;
            // read data prepared in setup so it is stable in access
            for (int d = 0; d < NUM_DB; d++) begin
                for (int h = 0; h < 2; h++) begin
                    if (db_hit(req.addr, d, h[0])) begin
                        hit = 1'b1;
                        st_nxt.rdata = pack8(st_r.db_route[d], h[0]);
                    end
                end
            end
            if (req.addr == sir_pkg::RXQ_ROUTE_LO) begin
                hit = 1'b1;
                st_nxt.rdata = pack8(st_r.rxq_route, 1'b0);
            end
            if (req.addr == sir_pkg::RXQ_ROUTE_HI) begin
                hit = 1'b1;
                st_nxt.rdata = pack8(st_r.rxq_route, 1'b1);
            end
            if (req.addr == sir_pkg::IRQ_STATUS) begin
                hit = 1'b1;
                st_nxt.rdata = {24'h0, st_r.status};
            end
            if (req.addr == sir_pkg::IRQ_MASK) begin
                hit = 1'b1;
                st_nxt.rdata = {24'h0, st_r.mask};
            end
            if (req.addr == sir_pkg::IRQ_PENDING) begin
                hit = 1'b1;
                st_nxt.rdata = {24'h0, st_r.dst};
            end
            st_nxt.slverr = !hit;
        end
        acc = req.sel && req.enable && (st_r.phase == sir_pkg::SIR_ACCESS);
        if (acc && req.write && !st_r.slverr) begin
            for (int d = 0; d < NUM_DB; d++) begin
                for (int h = 0; h < 2; h++) begin
                    if (db_hit(req.addr, d, h[0])) begin
                        for (int k = 0; k < 8; k++) begin
                            st_nxt.db_route[d][k + 8*h] =
                                req.wdata[4*k +: 4];
                        end
                    end
                end
            end
            for (int k = 0; k < 8; k++) begin
                if (req.addr == sir_pkg::RXQ_ROUTE_LO) begin
                    st_nxt.rxq_route[k] = req.wdata[4*k +: 4];
                end
                if (req.addr == sir_pkg::RXQ_ROUTE_HI) begin
                    st_nxt.rxq_route[k + 8] = req.wdata[4*k +: 4];
                end
            end
            if (req.addr == sir_pkg::IRQ_STATUS) begin
                st_nxt.status = st_r.status & ~req.wdata[7:0];
            end
            if (req.addr == sir_pkg::IRQ_MASK) begin
                st_nxt.mask = req.wdata[7:0];
            end
        end
        // a rising destination sets its sticky bit; set beats clear
        st_nxt.status = st_nxt.status | dst_rise;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // all state in one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign irq_destination_outputs = st_r.dst;
    assign irq = |(st_r.status & st_r.mask);
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr & st_r.ready;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // rx queue 0 lands on its coded destination
    a_rxq_route_reach: assert property (@(posedge pclk)
        disable iff (!presetn)
        (rx_queue_pending_status[0] && !st_r.rxq_route[0][3])
        |=> irq_destination_outputs[$past(st_r.rxq_route[0][2:0])])
        else $error("rx queue 0 not routed");
    // rx queue 8 lands on the destination of its high-word field
    a_rxq_hi_reach: assert property (@(posedge pclk)
        disable iff (!presetn)
        (rx_queue_pending_status[8] && !st_r.rxq_route[8][3])
        |=> irq_destination_outputs[$past(st_r.rxq_route[8][2:0])])
        else $error("rx queue 8 not routed");
    // doorbell 0 bit 5 lands on its coded destination
    a_db_route_reach: assert property (@(posedge pclk)
        disable iff (!presetn)
        (doorbell_pending_status[0][5] && !st_r.db_route[0][5][3])
        |=> irq_destination_outputs[$past(st_r.db_route[0][5][2:0])])
        else $error("doorbell bit not routed");
    // the last doorbell, high half, lands on its coded destination
    a_db_last_reach: assert property (@(posedge pclk)
        disable iff (!presetn)
        (doorbell_pending_status[NUM_DB-1][12]
         && !st_r.db_route[NUM_DB-1][12][3])
        |=> irq_destination_outputs[
            $past(st_r.db_route[NUM_DB-1][12][2:0])])
        else $error("last doorbell bit not routed");
    // a reserved code steers its source nowhere
    a_rsvd_code_quiet: assert property (@(posedge pclk)
        disable iff (!presetn)
        (doorbell_pending_status == '0) && st_r.rxq_route[0][3]
        && (rx_queue_pending_status == 16'h0001)
        |=> (irq_destination_outputs == 8'h00))
        else $error("reserved code reached a destination");
    // code 7 picks the highest destination and nothing else
    a_top_code_reach: assert property (@(posedge pclk)
        disable iff (!presetn)
        (doorbell_pending_status == '0) && st_r.rxq_route[7] == 4'h7
        && (rx_queue_pending_status == 16'h0080)
        |=> (irq_destination_outputs == 8'h80))
        else $error("code seven not on the top destination");
    // no pending source, no destination
    a_idle_no_out: assert property (@(posedge pclk)
        disable iff (!presetn)
        ((doorbell_pending_status == '0) && (rx_queue_pending_status == '0))
        |=> (irq_destination_outputs == 8'h00))
        else $error("output without pending status");
    // a lone pending queue shows on its destination only
    a_only_pending: assert property (@(posedge pclk)
        disable iff (!presetn)
        (doorbell_pending_status == '0) && st_r.rxq_route[2] == 4'h2
        && (rx_queue_pending_status == 16'h0004)
        |=> (irq_destination_outputs == 8'h04))
        else $error("destination shown without its pending bit");
    // low rx word: queue 7 in the top nibble
    a_rxlo_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == sir_pkg::RXQ_ROUTE_LO)
        |=> (st_r.rxq_route[7] == $past(pwdata[31:28])))
        else $error("rx route low write lost");
    // low rx word: queue 0 in the bottom nibble
    a_rxlo_q0_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == sir_pkg::RXQ_ROUTE_LO)
        |=> (st_r.rxq_route[0] == $past(pwdata[3:0])))
        else $error("rx route low field 0 write lost");
    // high rx word: queue 8 in the bottom nibble
    a_rxhi_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == sir_pkg::RXQ_ROUTE_HI)
        |=> (st_r.rxq_route[8] == $past(pwdata[3:0])))
        else $error("rx route high write lost");
    // high rx word: queue 15 in the top nibble
    a_rxhi_q15_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == sir_pkg::RXQ_ROUTE_HI)
        |=> (st_r.rxq_route[15] == $past(pwdata[31:28])))
        else $error("rx route high field 15 write lost");
    // routes come out of reset as zero, so every source hits destination 0
    a_route_reset_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        $rose(presetn)
        |-> (st_r.rxq_route == '0) && (st_r.db_route == '0))
        else $error("route fields not zero after reset");
    // a read of the low rx word returns queue 0 field
    a_read_back: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == sir_pkg::RXQ_ROUTE_LO)
        ##1 (psel && penable)
        |-> (prdata[3:0] == st_r.rxq_route[0]))
        else $error("rx route readback wrong");
    // a doorbell bit and a queue on one code share one destination
    a_or_merge: assert property (@(posedge pclk)
        disable iff (!presetn)
        doorbell_pending_status[0][0] && rx_queue_pending_status[0]
        && st_r.db_route[0][0] == st_r.rxq_route[0] && !st_r.rxq_route[0][3]
        |=> irq_destination_outputs[$past(st_r.rxq_route[0][2:0])])
        else $error("destination or merge broken");
    // the last doorbell and queue 3 merge when routed alike
    a_or_far: assert property (@(posedge pclk)
        disable iff (!presetn)
        doorbell_pending_status[NUM_DB-1][0] && rx_queue_pending_status[3]
        && st_r.db_route[NUM_DB-1][0] == st_r.rxq_route[3]
        && !st_r.rxq_route[3][3]
        |=> irq_destination_outputs[$past(st_r.rxq_route[3][2:0])])
        else $error("far or merge broken");
    // queue 15 uses a shared destination line
    a_shared_dst: assert property (@(posedge pclk)
        disable iff (!presetn)
        (rx_queue_pending_status[15] && st_r.rxq_route[15] == 4'h6)
        |=> irq_destination_outputs[6])
        else $error("queue 15 not on shared line");
    // doorbell 0 second word: bit 15 in the top nibble
    a_db_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == 12'(sir_pkg::DB_ROUTE_BASE + sir_pkg::DB_ROUTE_HI_OFS))
        |=> (st_r.db_route[0][15] == $past(pwdata[31:28])))
        else $error("doorbell route write lost");
    // doorbell 0 first word: bit 0 in the bottom nibble
    a_db_lo_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr
         && paddr == sir_pkg::DB_ROUTE_BASE)
        |=> (st_r.db_route[0][0] == $past(pwdata[3:0])))
        else $error("doorbell low route write lost");
    // the last doorbell pair sits one stride per doorbell above the base
    a_db_last_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pwrite && pready && !pslverr && paddr == 12'(
         sir_pkg::DB_ROUTE_BASE + (NUM_DB-1) * sir_pkg::DB_ROUTE_STRIDE))
        |=> (st_r.db_route[NUM_DB-1][0] == $past(pwdata[3:0])))
        else $error("last doorbell route write lost");

endmodule : sir_irq_route
`default_nettype wire

/* File: sir_pkg.sv */
package sir_pkg;

    // register offsets (byte addresses)
    localparam logic [11:0] DB_ROUTE_BASE = 12'h280;
    localparam logic [11:0] DB_ROUTE_STRIDE = 12'h010;
    localparam logic [11:0] DB_ROUTE_HI_OFS = 12'h004;
    localparam logic [11:0] RXQ_ROUTE_LO = 12'h2c0;
    localparam logic [11:0] RXQ_ROUTE_HI = 12'h2c4;
    localparam logic [11:0] IRQ_STATUS = 12'h2e0;
    localparam logic [11:0] IRQ_MASK = 12'h2e4;
    localparam logic [11:0] IRQ_PENDING = 12'h2e8;

    // geometry
    localparam int NUM_DB = 4;
    localparam int SRC_BITS = 16;
    localparam int NUM_DST = 8;
    localparam int FIELD_W = 4;
    localparam int FIELDS_PER_REG = 8;

    // field layout and reset values
    localparam int FIELD_RSVD_BIT = 3;
    localparam logic [3:0] ROUTE_RESET = 4'h0;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;

    // routing field array, one 4-bit code per source
    typedef logic [SRC_BITS-1:0][FIELD_W-1:0] sir_route_t;

    // apb request bundle
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sir_apb_req_s;

    // apb answer bundle
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } sir_apb_rsp_s;

    // bus slave phase
    typedef enum logic [0:0] {
        SIR_IDLE = 1'b0,
        SIR_ACCESS = 1'b1
    } sir_phase_e;

endpackage : sir_pkg

/* File: sir_route_mux.sv */
`timescale 1ns/1ps
`default_nettype none

// steers 16 pending sources onto 8 destinations by their route codes
module sir_route_mux (
    input wire logic [15:0] pending,
    input wire sir_pkg::sir_route_t route,
    output logic [7:0] dst
);

    // one-hot decode of a route code; reserved codes reach nothing
    function automatic logic [7:0] sir_decode(input logic [3:0] code);
        logic [7:0] oh;
        oh = 8'h00;
        if (!code[sir_pkg::FIELD_RSVD_BIT]) begin
            oh[code[2:0]] = 1'b1;
        end
        return oh;
    endfunction : sir_decode

    // or every pending source into its destination
    always_comb begin
        dst = 8'h00;
        for (int i = 0; i < sir_pkg::SRC_BITS; i++) begin
            if (pending[i]) begin
                dst = dst | sir_decode(route[i]);
            end
        end
    end

endmodule : sir_route_mux
`default_nettype wire

/* File: sir_pic_model.sv */
`timescale 1ns/1ps
`default_nettype none

// receiving interrupt controller: remembers every line it has seen high
module sir_pic_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] lines,
    input wire logic irq,
    output logic [7:0] seen_r,
    output logic irq_seen_r
);
    // sticky capture, cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_r <= 8'h00;
            irq_seen_r <= 1'b0;
        end else begin
            seen_r <= seen_r | lines;
            irq_seen_r <= irq_seen_r | irq;
        end
    end
endmodule : sir_pic_model

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0][15:0] db_stat = '0;
    logic [15:0] rxq_stat = 16'h0000;
    logic [7:0] dst;
    logic irq;
    logic [7:0] pic_seen;
    logic pic_irq;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    sir_irq_route #(.NUM_DB(4)) u_sir_irq_route (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .doorbell_pending_status(db_stat),
        .rx_queue_pending_status(rxq_stat),
        .irq_destination_outputs(dst), .irq(irq)
    );

    sir_pic_model u_sir_pic_model (
        .pclk(pclk), .presetn(presetn), .lines(dst), .irq(irq),
        .seen_r(pic_seen), .irq_seen_r(pic_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // compare, bus and stimulus helpers
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; holds the request until pready is sampled high, giving up after 50 cycles
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rdchk

    // apply source levels, then let routing and status settle
    task automatic src(input logic [63:0] db, input logic [15:0] rx);
        db_stat <= db;
        rxq_stat <= rx;
        repeat (3) @(posedge pclk);
    endtask : src

    // route register address: doorbell pairs first, then rx low and high
    function automatic logic [11:0] ra(input int i);
        if (i < 8) begin
            return 12'(sir_pkg::DB_ROUTE_BASE + sir_pkg::DB_ROUTE_STRIDE
                * (i / 2) + sir_pkg::DB_ROUTE_HI_OFS * (i % 2));
        end
        return 12'(sir_pkg::RXQ_ROUTE_LO + 4 * (i - 8));
    endfunction : ra

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++) rdchk("route reset", ra(i), 0);
        // even registers map field k to k, odd ones to k xor 1
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, ra(i), 32'h76543210 ^ (32'h11111111 * (i % 2)));
            rdchk("route rw", ra(i), 32'h76543210 ^ (32'h11111111 * (i % 2)));
        end
        for (int q = 0; q < 16; q++) begin
            src('0, 16'(1) << q);
            check("rx route", dst, 32'h1 << (q < 8 ? q : (q - 8) ^ 1));
        end
        // each doorbell low register steers bits 0..7 to its own index
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, ra(2 * d), 32'h11111111 * d);
            for (int b = 0; b < 16; b++) begin
                src(64'(1) << (16 * d + b), '0);
                check("db route", dst, 32'h1 << (b < 8 ? d : (b - 8) ^ 1));
            end
        end
        src(64'h0003_0000_0000_0001, 16'h0009);
        check("or dst", dst, 32'h0000_0009);
        src('0, 16'h0000);
        check("idle dst", dst, 0);
        apb(1'b1, ra(8), 32'h7654321f);
        src('0, 16'h0001);
        check("reserved", dst, 0);
        src('0, 16'h0000);
        apb(1'b0, 12'h300, 0);
        check("unmapped err", {31'h0, err}, 1);
        check("unmapped data", rd, 0);
        // status, mask and level interrupt
        apb(1'b1, sir_pkg::IRQ_STATUS, 32'h0000_00ff);
        rdchk("status clr", sir_pkg::IRQ_STATUS, 0);
        apb(1'b1, sir_pkg::IRQ_MASK, 0);
        src('0, 16'h0004);
        check("masked irq", {31'h0, irq}, 0);
        rdchk("status set", sir_pkg::IRQ_STATUS, 32'h4);
        rdchk("lines", sir_pkg::IRQ_PENDING, 32'h4);
        apb(1'b1, sir_pkg::IRQ_MASK, 32'h4);
        rdchk("mask rw", sir_pkg::IRQ_MASK, 32'h4);
        check("irq on", {31'h0, irq}, 1);
        apb(1'b1, sir_pkg::IRQ_STATUS, 32'h4);
        check("irq off", {31'h0, irq}, 0);
        check("pic lines", pic_seen, 32'hff);
        check("pic irq", {31'h0, pic_irq}, 1);
        // second reset in mid-run: routes and interrupt return to zero
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("irq after reset", {31'h0, irq}, 0);
        rdchk("route reset rx", ra(8), 0);
        rdchk("route reset db", ra(7), 0);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
